// ---- hdl/crs_core_regs.sv ----
`timescale 1ns/1ps
// architectural state of the core: data registers, pc, flags, stack
module crs_core_regs #(
   parameter int PC_W = crs_pkg::PC_WIDTH,
   parameter int DEPTH = crs_pkg::STACK_DEPTH,
   parameter int CORE_DIV = crs_pkg::CORE_DIV,
   parameter int PERIPH_DIV = crs_pkg::PERIPH_DIV
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rstn,
   // data-space access
   input crs_pkg::crs_dbus_t dbus,
   output logic [7:0] rdata,
   output logic hit,
   // sequencer control, sampled on the machine cycle strobe
   input crs_pkg::crs_ctrl_t ctrl,
   input wire logic [PC_W-1:0] vector,
   // pc and flags
   output logic [PC_W-1:0] program_counter,
   output logic carry,
   output logic zero,
   output crs_pkg::crs_ctx_t context_now,
   output logic stack_empty,
   // timing
   output logic cycle_strobe,
   output logic periph_tick
);
   initial begin
      if (PC_W != 12 || CORE_DIV < 2 || PERIPH_DIV < 2 ||
          CORE_DIV > 15 || PERIPH_DIV > 15) begin
         $error("crs_core_regs: unsupported width or divider");
      end
   end

   logic [7:0] acc_reg, ptr_a_reg, ptr_b_reg, sd_a_reg, sd_b_reg;
   logic [PC_W-1:0] pc_reg, pc_next;
   logic [3:0] core_cnt_reg, per_cnt_reg;
   logic strobe_reg, tick_reg;
   logic main_carry, main_zero, irq_carry, irq_zero, nmi_carry, nmi_zero;
   crs_pkg::crs_ctx_t ctx_reg, ctx_next, saved_irq_reg, saved_main_reg;
   logic car_next, zer_next, cur_c;
   logic [PC_W-1:0] top_data;
   logic stk_empty;

   // address decode into named wires
   wire sel_acc = dbus.addr == crs_pkg::ADDR_ACCUMULATOR;
   wire sel_pa = dbus.addr == crs_pkg::ADDR_INDEX_FIRST;
   wire sel_pb = dbus.addr == crs_pkg::ADDR_INDEX_SECOND;
   wire sel_sa = dbus.addr == crs_pkg::ADDR_SHORT_FIRST;
   wire sel_sb = dbus.addr == crs_pkg::ADDR_SHORT_SECOND;
   wire any_sel = sel_acc | sel_pa | sel_pb | sel_sa | sel_sb;
   wire run = strobe_reg;
   wire do_push = run && ctrl.push;
   wire do_pop = run && ctrl.pc_src == crs_pkg::CRS_PC_RETURN;

   // read mux; other addresses return zero and hit low for the memory
   assign hit = dbus.rd && any_sel;
   assign rdata = sel_acc ? acc_reg : sel_pa ? ptr_a_reg :
                  sel_pb ? ptr_b_reg : sel_sa ? sd_a_reg :
                  sel_sb ? sd_b_reg : 8'h00;

   // machine cycle and peripheral dividers
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         core_cnt_reg <= 4'h0;
         per_cnt_reg <= 4'h0;
         strobe_reg <= 1'b0;
         tick_reg <= 1'b0;
      end else begin
         core_cnt_reg <= (core_cnt_reg == 4'(CORE_DIV - 1)) ? 4'h0 :
                         core_cnt_reg + 4'h1;
         strobe_reg <= core_cnt_reg == 4'(CORE_DIV - 1);
         per_cnt_reg <= (per_cnt_reg == 4'(PERIPH_DIV - 1)) ? 4'h0 :
                        per_cnt_reg + 4'h1;
         tick_reg <= per_cnt_reg == 4'(PERIPH_DIV - 1);
      end
   end
   assign cycle_strobe = strobe_reg;
   assign periph_tick = tick_reg;

   // data registers; software writes land at once, alu result via acc writes
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         acc_reg <= crs_pkg::DATA_RESET;
         ptr_a_reg <= crs_pkg::DATA_RESET;
         ptr_b_reg <= crs_pkg::DATA_RESET;
         sd_a_reg <= crs_pkg::DATA_RESET;
         sd_b_reg <= crs_pkg::DATA_RESET;
      end else if (dbus.wr) begin
         if (sel_acc) acc_reg <= dbus.wdata;
         if (sel_pa) ptr_a_reg <= dbus.wdata;
         if (sel_pb) ptr_b_reg <= dbus.wdata;
         if (sel_sa) sd_a_reg <= dbus.wdata;
         if (sel_sb) sd_b_reg <= dbus.wdata;
      end
   end

   // branch sum through the adder, sign chosen by direction
   function automatic logic [11:0] branch_sum(input logic [11:0] pc,
                                              input logic [7:0] off,
                                              input logic back);
      logic [11:0] ext;
      ext = {4'h0, off};
      branch_sum = back ? pc - ext : pc + ext;
   endfunction

   // pc source select; empty return falls through to the next address
   always_comb begin
      pc_next = pc_reg;
      case (ctrl.pc_src)
         crs_pkg::CRS_PC_STEP: pc_next = pc_reg + 12'h001;
         crs_pkg::CRS_PC_JUMP: pc_next = ctrl.target;
         crs_pkg::CRS_PC_BRANCH:
            pc_next = branch_sum(pc_reg, ctrl.offset,
                                 ctrl.branch_back);
         crs_pkg::CRS_PC_VECTOR: pc_next = vector;
         crs_pkg::CRS_PC_RETURN:
            pc_next = stk_empty ? pc_reg + 12'h001 : top_data;
         crs_pkg::CRS_PC_HOLD: pc_next = pc_reg;
         default: pc_next = pc_reg + 12'h001;
      endcase
   end

   // pc moves only on the cycle strobe, together with any push
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         pc_reg <= crs_pkg::RESET_VECTOR;
      end else if (run) begin
         pc_reg <= pc_next;
      end
   end
   assign program_counter = pc_reg;

   // pushed value is the return address, the pc before the load
   crs_stack #(.WIDTH(PC_W), .DEPTH(DEPTH)) u_stack (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .push(do_push),
      .pop(do_pop),
      .push_data(pc_reg),
      .top_data(top_data),
      .empty(stk_empty)
   );
   assign stack_empty = stk_empty;

   // context tracking; one saved slot per nesting level is enough
   // because an irq only interrupts main and an nmi may interrupt either
   always_comb begin
      ctx_next = ctx_reg;
      if (run && ctrl.enter_nmi) begin
         ctx_next = crs_pkg::CRS_CTX_NMI;
      end else if (run && ctrl.enter_irq) begin
         ctx_next = crs_pkg::CRS_CTX_IRQ;
      end else if (run && ctrl.irq_exit) begin
         case (ctx_reg)
            crs_pkg::CRS_CTX_NMI: ctx_next = saved_irq_reg;
            crs_pkg::CRS_CTX_IRQ: ctx_next = saved_main_reg;
            default: ctx_next = crs_pkg::CRS_CTX_MAIN;
         endcase
      end
   end

   // save the context being left; nmi after reset returns to main
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         ctx_reg <= crs_pkg::CRS_CTX_NMI;
         saved_irq_reg <= crs_pkg::CRS_CTX_MAIN;
         saved_main_reg <= crs_pkg::CRS_CTX_MAIN;
      end else begin
         ctx_reg <= ctx_next;
         if (run && ctrl.enter_nmi) saved_irq_reg <= ctx_reg;
         else if (run && ctrl.enter_irq) saved_main_reg <= ctx_reg;
      end
   end
   assign context_now = ctx_reg;

   // active pair mux
   assign cur_c = (ctx_reg == crs_pkg::CRS_CTX_NMI) ? nmi_carry :
                  (ctx_reg == crs_pkg::CRS_CTX_IRQ) ? irq_carry : main_carry;
   assign zero = (ctx_reg == crs_pkg::CRS_CTX_NMI) ? nmi_zero :
                 (ctx_reg == crs_pkg::CRS_CTX_IRQ) ? irq_zero : main_zero;
   assign carry = cur_c;

   // flag update from the alu outcome
   always_comb begin
      car_next = cur_c;
      zer_next = zero;
      case (ctrl.flag_op)
         crs_pkg::CRS_FL_ARITH: begin
            car_next = ctrl.carry_in;
            zer_next = ctrl.result == 8'h00;
         end
         crs_pkg::CRS_FL_LOGIC: begin
            car_next = ctrl.rotate ? ctrl.carry_in : cur_c;
            zer_next = ctrl.result == 8'h00;
         end
         crs_pkg::CRS_FL_BIT: car_next = ctrl.bit_value;
         default: car_next = cur_c;
      endcase
   end

   // only the pair of the running context is written
   wire fl_we = run && ctrl.flag_op != crs_pkg::CRS_FL_NONE;
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         main_carry <= 1'b0;
         main_zero <= 1'b0;
         irq_carry <= 1'b0;
         irq_zero <= 1'b0;
         nmi_carry <= 1'b0;
         nmi_zero <= 1'b0;
      end else if (fl_we) begin
         case (ctx_reg)
            crs_pkg::CRS_CTX_NMI: begin
               nmi_carry <= car_next;
               nmi_zero <= zer_next;
            end
            crs_pkg::CRS_CTX_IRQ: begin
               irq_carry <= car_next;
               irq_zero <= zer_next;
            end
            default: begin
               main_carry <= car_next;
               main_zero <= zer_next;
            end
         endcase
      end
   end
endmodule

// ---- hdl/crs_pkg.sv ----
// What this block does
// - 8-bit accumulator, read and written as data location ffh.
// - two pointer registers sit at data addresses 80h and 81h.
// - two short-direct holding registers sit at data addresses 82h, 83h.
// - program counter is 12 bits and spans 4096 program bytes.
// - pc loads jump, branch sum, vector, reset vector or pop; holds on hold; else +1.
// - relative branch sums pc and offset in the alu adder.
// - three carry/zero pairs; interrupt and nmi entry select their pair.
// - interrupt return reselects the pair in use before entry.
// - switching alters no pair; only the active pair is touched.
// - carry from add/sub borrow, bit test value, and rotate left.
// - zero set when the last add/sub or logic result is zero, else cleared; bit test leaves zero unchanged.
// - after reset the core runs in nmi context with the nmi pair.
// - six 12-bit stack levels; push shifts down, pc into level one.
// - return pops level one into pc and shifts remaining levels up.
// - return on empty stack keeps the stack and continues sequentially.
// - machine cycle is 13 clocks; a divide-by-12 tick feeds peripherals.
// - instructions take two, four or five machine cycles.
// - pc increments after the current instruction address is read.
package crs_pkg;
   localparam logic [7:0] ADDR_INDEX_FIRST = 8'h80;
   localparam logic [7:0] ADDR_INDEX_SECOND = 8'h81;
   localparam logic [7:0] ADDR_SHORT_FIRST = 8'h82;
   localparam logic [7:0] ADDR_SHORT_SECOND = 8'h83;
   localparam logic [7:0] ADDR_ACCUMULATOR = 8'hff;
   localparam int PC_WIDTH = 12;
   localparam int STACK_DEPTH = 6;
   localparam int CORE_DIV = 13;
   localparam int PERIPH_DIV = 12;
   localparam logic [11:0] RESET_VECTOR = 12'hffe;
   localparam logic [7:0] DATA_RESET = 8'h00;

   // pc update source
   typedef enum logic [2:0] {
      CRS_PC_STEP = 3'h0,
      CRS_PC_JUMP = 3'h1,
      CRS_PC_BRANCH = 3'h2,
      CRS_PC_VECTOR = 3'h3,
      CRS_PC_RETURN = 3'h4,
      CRS_PC_HOLD = 3'h5
   } crs_pc_src_t;

   // flag context, gray along normal -> irq -> nmi
   typedef enum logic [1:0] {
      CRS_CTX_MAIN = 2'b00,
      CRS_CTX_IRQ = 2'b01,
      CRS_CTX_NMI = 2'b11
   } crs_ctx_t;

   // alu flag operation
   typedef enum logic [1:0] {
      CRS_FL_NONE = 2'h0,
      CRS_FL_ARITH = 2'h1,
      CRS_FL_LOGIC = 2'h2,
      CRS_FL_BIT = 2'h3
   } crs_flop_t;

   // one machine cycle worth of sequencer control
   typedef struct packed {
      crs_pc_src_t pc_src;
      logic [11:0] target;
      logic [7:0] offset;
      logic branch_back;
      logic push;
      logic enter_irq;
      logic enter_nmi;
      logic irq_exit;
      crs_flop_t flag_op;
      logic [7:0] result;
      logic carry_in;
      logic bit_value;
      logic rotate;
   } crs_ctrl_t;

   // data-space access
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } crs_dbus_t;
endpackage

// ---- hdl/crs_stack.sv ----
`timescale 1ns/1ps
// hardware return stack, shift register lifo with occupancy count
module crs_stack #(
   parameter int WIDTH = 12,
   parameter int DEPTH = 6
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rstn,
   // control
   input wire logic push,
   input wire logic pop,
   input wire logic [WIDTH-1:0] push_data,
   // status
   output logic [WIDTH-1:0] top_data,
   output logic empty
);
   initial begin
      // the occupancy count is four bits wide
      if (DEPTH < 2 || DEPTH > 15 || WIDTH < 1) begin
         $error("crs_stack: DEPTH must be 2 to 15");
      end
   end

   logic [WIDTH-1:0] level_reg [DEPTH];
   logic [3:0] count_reg;

   assign top_data = level_reg[0];
   assign empty = (count_reg == 4'h0);

   // shift down on push (deepest lost), up on pop; empty pop holds
   always_ff @(posedge ref_clk) begin
      if (push) begin
         level_reg[0] <= push_data;
         for (int i = 1; i < DEPTH; i++) begin
            level_reg[i] <= level_reg[i-1];
         end
      end else if (pop && !empty) begin
         for (int i = 0; i < DEPTH - 1; i++) begin
            level_reg[i] <= level_reg[i+1];
         end
      end
   end

   // occupancy saturates at depth, so overflow stays at the deepest point
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         count_reg <= 4'h0;
      end else if (push && count_reg != 4'(DEPTH)) begin
         count_reg <= count_reg + 4'h1;
      end else if (!push && pop && !empty) begin
         count_reg <= count_reg - 4'h1;
      end
   end
endmodule

// ---- bench/crs_core_regs_asserts.sv ----
`timescale 1ns/1ps
// port-level checks on the core state block
module crs_core_regs_asserts #(
   parameter int PC_W = 12,
   parameter int DEPTH = 6,
   parameter int CORE_DIV = 13,
   parameter int PERIPH_DIV = 12
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rstn,
   // data side
   input crs_pkg::crs_dbus_t dbus,
   input wire logic [7:0] rdata,
   input wire logic hit,
   // sequencer side
   input crs_pkg::crs_ctrl_t ctrl,
   input wire logic [PC_W-1:0] vector,
   input wire logic [PC_W-1:0] program_counter,
   input wire logic carry,
   input wire logic zero,
   input crs_pkg::crs_ctx_t context_now,
   input wire logic stack_empty,
   input wire logic cycle_strobe,
   input wire logic periph_tick
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rstn);
   // decodes; plain excludes context moves so the flag pair is known
   wire mapped = dbus.addr inside {8'h80, 8'h81, 8'h82, 8'h83, 8'hff};
   wire st = cycle_strobe;
   wire s_step = st && ctrl.pc_src == crs_pkg::CRS_PC_STEP;
   wire s_jump = st && ctrl.pc_src == crs_pkg::CRS_PC_JUMP;
   wire s_br = st && ctrl.pc_src == crs_pkg::CRS_PC_BRANCH;
   wire s_ret = st && ctrl.pc_src == crs_pkg::CRS_PC_RETURN;
   wire plain = st && !ctrl.enter_irq && !ctrl.enter_nmi && !ctrl.irq_exit;
   wire s_ari = plain && ctrl.flag_op == crs_pkg::CRS_FL_ARITH;

   AST_CORE_GAP: assert property (st |=> (!st)[*8] ##1 (!st)[*4] ##1 st)
      else $error("core strobe spacing wrong");
   AST_TICK_GAP: assert property (periph_tick |=> (!periph_tick)[*8]
      ##1 (!periph_tick)[*3] ##1 periph_tick)
      else $error("peripheral tick spacing wrong");
   AST_HIT_DECODE: assert property (hit == (dbus.rd && mapped))
      else $error("hit does not match address decode");
   AST_WRITE_READ: assert property (dbus.wr && mapped ##1
      dbus.addr == $past(dbus.addr) |-> rdata == $past(dbus.wdata))
      else $error("written byte not read back");
   AST_PC_STEP: assert property (s_step |=>
      program_counter == $past(program_counter) + 1'b1)
      else $error("pc step wrong");
   AST_PC_JUMP: assert property (s_jump |=>
      program_counter == $past(ctrl.target))
      else $error("pc jump wrong");
   AST_PC_BRANCH: assert property (s_br |=> program_counter ==
      ($past(ctrl.branch_back) ? $past(program_counter) - $past(ctrl.offset)
      : $past(program_counter) + $past(ctrl.offset)))
      else $error("pc branch sum wrong");
   AST_NMI_ENTRY: assert property (st && ctrl.enter_nmi |=>
      context_now == crs_pkg::CRS_CTX_NMI)
      else $error("nmi entry context wrong");
   AST_STATE_HOLD: assert property (!st |=> $stable(program_counter)
      && $stable(context_now) && $stable(carry) && $stable(zero))
      else $error("state moved without strobe");
   AST_EMPTY_RET: assert property (s_ret && stack_empty |=>
      stack_empty && program_counter == $past(program_counter) + 1'b1)
      else $error("return on empty stack wrong");
   AST_RESET_STATE: assert property ($rose(rstn) |->
      program_counter == crs_pkg::RESET_VECTOR
      && context_now == crs_pkg::CRS_CTX_NMI)
      else $error("state after reset wrong");
   AST_ARITH_FLAGS: assert property (s_ari |=>
      zero == ($past(ctrl.result) == 8'h00) && carry == $past(ctrl.carry_in))
      else $error("arithmetic flags wrong");

   // main scenarios reached
   cover property (s_jump && ctrl.push);
   cover property (s_ret && stack_empty);
   cover property (st && ctrl.enter_irq);
   cover property (plain && ctrl.flag_op == crs_pkg::CRS_FL_LOGIC
      && ctrl.rotate);
endmodule

bind crs_core_regs crs_core_regs_asserts #(.PC_W(PC_W), .DEPTH(DEPTH),
   .CORE_DIV(CORE_DIV), .PERIPH_DIV(PERIPH_DIV)) i_chk (
   .ref_clk(ref_clk), .rstn(rstn), .dbus(dbus), .rdata(rdata), .hit(hit),
   .ctrl(ctrl), .vector(vector), .program_counter(program_counter),
   .carry(carry), .zero(zero), .context_now(context_now),
   .stack_empty(stack_empty), .cycle_strobe(cycle_strobe),
   .periph_tick(periph_tick));

// ---- bench/crs_periph_model.sv ----
`timescale 1ns/1ps
// peripheral side: timer, converter and watchdog see only the tick
module crs_periph_model (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rstn,
   // divided tick from the core
   input wire logic periph_tick,
   // running total, differenced by the bench so phase does not matter
   output logic [15:0] tick_count
);
   // advance once per tick, never per core clock
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         tick_count <= 16'h0000;
      end else if (periph_tick) begin
         tick_count <= tick_count + 16'h0001;
      end
   end
endmodule

// ---- bench/crs_core_regs_test.sv ----
`timescale 1ns/1ps
module crs_core_regs_test;
   localparam crs_pkg::crs_pc_src_t JMP = crs_pkg::CRS_PC_JUMP;
   localparam crs_pkg::crs_pc_src_t BRA = crs_pkg::CRS_PC_BRANCH;
   localparam crs_pkg::crs_pc_src_t RET = crs_pkg::CRS_PC_RETURN;
   localparam crs_pkg::crs_pc_src_t STP = crs_pkg::CRS_PC_STEP;
   localparam crs_pkg::crs_pc_src_t VEC = crs_pkg::CRS_PC_VECTOR;
   localparam crs_pkg::crs_ctx_t NMI = crs_pkg::CRS_CTX_NMI;
   localparam crs_pkg::crs_ctx_t IRQ = crs_pkg::CRS_CTX_IRQ;
   localparam crs_pkg::crs_ctx_t MAIN = crs_pkg::CRS_CTX_MAIN;
   logic ref_clk = 1'b0;
   logic rstn = 1'b0;
   crs_pkg::crs_dbus_t dbus = '0;
   // idle control holds the pc; the struct is 41 bits wide
   crs_pkg::crs_ctrl_t ctrl = {crs_pkg::CRS_PC_HOLD, 38'h0};
   crs_pkg::crs_ctrl_t idle = {crs_pkg::CRS_PC_HOLD, 38'h0};
   logic [11:0] vector = 12'h5a5;
   logic [7:0] rdata;
   logic hit, carry, zero, stack_empty, cycle_strobe, periph_tick;
   logic [11:0] program_counter;
   crs_pkg::crs_ctx_t context_now;
   logic [15:0] tick_count;
   int err_count = 0;
   int num_checks = 0;

   // 125 MHz
   always #4 ref_clk = ~ref_clk;

   crs_core_regs i_dut (.ref_clk(ref_clk), .rstn(rstn), .dbus(dbus),
      .rdata(rdata), .hit(hit), .ctrl(ctrl), .vector(vector),
      .program_counter(program_counter), .carry(carry), .zero(zero),
      .context_now(context_now), .stack_empty(stack_empty),
      .cycle_strobe(cycle_strobe), .periph_tick(periph_tick));
   crs_periph_model i_periph (.ref_clk(ref_clk), .rstn(rstn),
      .periph_tick(periph_tick), .tick_count(tick_count));

   task automatic chk(input logic [11:0] got, input logic [11:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic give_verdict();
      $display("checks=%0d errors=%0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // byte write, one clock with wr high
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge ref_clk);
      dbus = '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(negedge ref_clk);
      dbus.wr = 1'b0;
   endtask
   // read answers combinationally, so look once it settles
   task automatic rdchk(input logic [7:0] a, input logic [7:0] d, logic h);
      @(negedge ref_clk);
      dbus = '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      #1;
      chk(12'(rdata), 12'(d));
      chk(12'(hit), 12'(h));
   endtask
   // ctrl is only taken on a strobe edge; idle holds so no op repeats
   task automatic op(input crs_pkg::crs_ctrl_t c);
      int n;
      n = 0;
      @(negedge ref_clk);
      while (cycle_strobe !== 1'b1 && n < 20) begin
         @(negedge ref_clk);
         n++;
      end
      if (n >= 20) begin
         err_count++;
         give_verdict();
      end
      ctrl = c;
      @(negedge ref_clk);
      ctrl = idle;
      #1;
   endtask
   task automatic pc_op(crs_pkg::crs_pc_src_t s, logic [11:0] t,
         logic [7:0] o, logic b, logic p, logic [11:0] e);
      crs_pkg::crs_ctrl_t c;
      c = idle;
      c.pc_src = s;
      c.target = t;
      c.offset = o;
      c.branch_back = b;
      c.push = p;
      op(c);
      chk(program_counter, e);
   endtask
   task automatic fz(input logic [1:0] x, input logic c, input logic z);
      chk(12'(context_now), 12'(x));
      chk(12'(carry), 12'(c));
      chk(12'(zero), 12'(z));
   endtask

   task automatic t_reset();
      chk(program_counter, crs_pkg::RESET_VECTOR);
      fz(NMI, 1'b0, 1'b0);
      chk(12'(stack_empty), 12'h001);
   endtask
   task automatic t_regs();
      logic [7:0] a [5];
      a = '{8'h80, 8'h81, 8'h82, 8'h83, 8'hff};
      foreach (a[i]) wr(a[i], a[i] ^ 8'h5a);
      wr(8'h84, 8'hee);
      foreach (a[i]) rdchk(a[i], a[i] ^ 8'h5a, 1'b1);
      rdchk(8'h84, 8'h00, 1'b0);
   endtask
   task automatic t_pc();
      pc_op(JMP, 12'h123, 8'h00, 1'b0, 1'b0, 12'h123);
      pc_op(STP, 12'h000, 8'h00, 1'b0, 1'b0, 12'h124);
      pc_op(BRA, 12'h000, 8'h05, 1'b0, 1'b0, 12'h129);
      pc_op(BRA, 12'h000, 8'h0a, 1'b1, 1'b0, 12'h11f);
      pc_op(VEC, 12'h000, 8'h00, 1'b0, 1'b0, 12'h5a5);
      pc_op(JMP, 12'hfff, 8'h00, 1'b0, 1'b0, 12'hfff);
      pc_op(STP, 12'h000, 8'h00, 1'b0, 1'b0, 12'h000);
   endtask
   // seven calls into six levels: the oldest return address is lost
   task automatic t_stack();
      logic [11:0] q [$];
      logic [11:0] p;
      p = 12'h000;
      for (int i = 0; i < 7; i++) begin
         q.push_front(p);
         if (q.size() > 6) q.pop_back();
         p = 12'h200 + 12'(i);
         pc_op(JMP, p, 8'h00, 1'b0, 1'b1, p);
      end
      while (q.size() > 0) begin
         pc_op(RET, 12'h000, 8'h00, 1'b0, 1'b0, q.pop_front());
      end
      chk(12'(stack_empty), 12'h001);
      pc_op(RET, 12'h000, 8'h00, 1'b0, 1'b0, 12'h201);
   endtask
   task automatic t_flags();
      crs_pkg::crs_ctrl_t c;
      c = idle;
      c.flag_op = crs_pkg::CRS_FL_ARITH;
      c.carry_in = 1'b1;
      op(c);
      fz(NMI, 1'b1, 1'b1);
      c = idle;
      c.irq_exit = 1'b1;
      op(c);
      fz(MAIN, 1'b0, 1'b0);
      c = idle;
      c.enter_irq = 1'b1;
      op(c);
      fz(IRQ, 1'b0, 1'b0);
      c = idle;
      c.flag_op = crs_pkg::CRS_FL_BIT;
      c.bit_value = 1'b1;
      c.result = 8'h04;
      op(c);
      fz(IRQ, 1'b1, 1'b0);
      c = idle;
      c.enter_nmi = 1'b1;
      op(c);
      fz(NMI, 1'b1, 1'b1);
      c = idle;
      c.irq_exit = 1'b1;
      op(c);
      fz(IRQ, 1'b1, 1'b0);
      op(c);
      fz(MAIN, 1'b0, 1'b0);
      // logic ops: rotate takes carry_in, otherwise carry is left alone
      c = idle;
      c.flag_op = crs_pkg::CRS_FL_LOGIC;
      c.rotate = 1'b1;
      c.carry_in = 1'b1;
      c.result = 8'h01;
      op(c);
      fz(MAIN, 1'b1, 1'b0);
      c.rotate = 1'b0;
      c.carry_in = 1'b0;
      c.result = 8'h00;
      op(c);
      fz(MAIN, 1'b1, 1'b1);
   endtask
   // 156 clocks hold exactly 13 ticks and 12 strobes whatever the phase
   task automatic t_ticks();
      logic [15:0] t0;
      int s;
      s = 0;
      @(negedge ref_clk);
      t0 = tick_count;
      repeat (156) begin
         @(negedge ref_clk);
         if (cycle_strobe === 1'b1) s++;
      end
      chk(12'(tick_count - t0), 12'd13);
      chk(12'(s), 12'd12);
   endtask

   initial begin
      repeat (16) @(posedge ref_clk);
      @(negedge ref_clk);
      rstn = 1'b1;
      t_reset();
      t_regs();
      t_pc();
      t_stack();
      t_flags();
      t_ticks();
      give_verdict();
   end
endmodule
